// file: rtcal_top.sv
// module: rtc alarm comparison and two-wire serial slave
// Behaviour
// R1: compare alarm field only when disable clear
// R2: all enabled matches first time set flag
// R3: flag sticky until software clears it
// R4: re-set only on new match entry
// R5: disabled alarm registers ignored in decision
// R6: minute alarm disable D7, BCD D6-D0
// R7: hour/date alarm disable D7, D6 zero
// R8: weekday alarm disable D7, D2-D0 value
// R9: lines released when bus idle
// R10: detect start and stop conditions
// R11: repeated start detected like start
// R12: sample data on clock high, drive low
// R13: bytes of eight bits, unlimited count
// R14: address pointer increments after each byte
// R15: acknowledge driven low in ninth clock
// R16: master releases data after its ack
// R17: no master ack ends transmit, await stop
// R18: respond only to own seven-bit address
// R19: direction bit zero, one means read
// R20: master avoids test-mode addresses
// R21: write: address, pointer, data bytes, stop
// R22: plain read starts at current pointer
// R23: writing zero clears flag, one keeps
// R24: interrupt enable gates flag report
// R25: no response beyond the last register; a read still sends one byte past it, from register ptr_q[3:0]
`timescale 1ns/1ps
`default_nettype none
module rtcal_top
  import rtcal_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       ARST_N,
  // two-wire bus, open drain
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  // running time from the counter domain, BCD
  input  wire logic [7:0] TIME_MIN,
  input  wire logic [7:0] TIME_HOUR,
  input  wire logic [7:0] TIME_DATE,
  input  wire logic [7:0] TIME_WDAY,
  // alarm status
  output logic            ALARM_FLAG,
  output logic            ALARM_IRQ
);
  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [2:0] scl_sy_q;
  logic [2:0] sda_sy_q;
  logic       scl_q;
  logic       sda_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
    end
    else
    begin
      scl_sy_q <= {scl_sy_q[1:0], SCL_IN};
      sda_sy_q <= {sda_sy_q[1:0], SDA_IN};
    end
  end

  // a level counts only once stages two and three agree
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      if (scl_sy_q[1] == scl_sy_q[2])
      begin
        scl_q <= scl_sy_q[2];
      end
      if (sda_sy_q[1] == sda_sy_q[2])
      begin
        sda_q <= sda_sy_q[2];
      end
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_q & ~scl_prev_q;
  assign scl_fall  = ~scl_q & scl_prev_q;
  // R10 R11 start and stop
  assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_det  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

  // ****************************************************
  // serial slave state
  // ****************************************************
  rtcal_state_t state_q;
  logic [3:0]   bit_cnt_q;
  logic [7:0]   shift_q;
  logic [7:0]   ptr_q;
  logic         first_q;
  logic         ptr_set_q;
  logic         rd_dir_q;
  logic         ack_q;
  logic         mack_q;
  logic         sda_drv_q;
  logic         wr_stb;
  logic [7:0]   rx_byte;
  logic         ptr_ok;
  logic         af_wr_clr;

  assign rx_byte = {shift_q[6:0], sda_q};
  // R25 valid register range
  assign ptr_ok  = (ptr_q <= OFS_LAST);

  rtcal_mem_if mif ();
  rtcal_regmem u_mem (
    .MCLK   (MCLK),
    .ARST_N (ARST_N),
    .port   (mif.mem)
  );

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= ZERO_BYTE;
      first_q   <= 1'b0;
      ptr_set_q <= 1'b0;
      rd_dir_q  <= 1'b0;
      ack_q     <= 1'b0;
      mack_q    <= 1'b0;
    end
    else if (start_det)
    begin
      state_q   <= ST_RX;
      bit_cnt_q <= 4'h0;
      first_q   <= 1'b1;
      ptr_set_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_RX:
        begin
          // R12 R13 sample on rising clock
          if (scl_rise)
          begin
            shift_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall && bit_cnt_q == BITS_BYTE)
          begin
            bit_cnt_q <= 4'h0;
            if (first_q)
            begin
              // R18 R19 own address and direction
              ack_q    <= (shift_q[7:1] == SLAVE_ADDR);
              rd_dir_q <= shift_q[0];
              state_q  <= (shift_q[7:1] == SLAVE_ADDR) ? ST_ACK : ST_WAITP;
            end
            else
            begin
              // R25 refuse data beyond the map
              ack_q   <= ptr_set_q ? ptr_ok : 1'b1;
              state_q <= (ptr_set_q && !ptr_ok) ? ST_WAITP : ST_ACK;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            first_q   <= 1'b0;
            ptr_set_q <= ptr_set_q | ~first_q;
            state_q   <= (first_q && rd_dir_q) ? ST_TX : ST_RX;
            shift_q   <= mif.rdata;
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q   <= {shift_q[6:0], 1'b0};
            if (bit_cnt_q == BITS_BYTE - 4'h1)
            begin
              bit_cnt_q <= 4'h0;
              state_q   <= ST_TXACK;
            end
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            mack_q <= ~sda_q;
          end
          // R17 no master ack: release and wait
          if (scl_fall)
          begin
            state_q <= mack_q && ptr_ok ? ST_TX : ST_WAITP;
            shift_q <= mif.rdata;
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ****************************************************
  // address pointer and register writes
  // ****************************************************
  // R21 second byte sets pointer, rest are data
  assign wr_stb = (state_q == ST_ACK) && scl_fall && !first_q && ptr_set_q;

  // R14 R22 pointer auto increment
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ptr_q <= ZERO_BYTE;
    end
    else if (state_q == ST_ACK && scl_fall && !first_q)
    begin
      ptr_q <= ptr_set_q ? ptr_q + 8'h01 : shift_q;
    end
    else if (state_q == ST_TXACK && scl_fall)
    begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // R6 R7 R8 unimplemented bits kept at zero
  function automatic logic [7:0] wmask(input logic [7:0] a);
    logic [7:0] m;
    m = ZERO_BYTE;
    if (a == OFS_AL_MIN)
    begin
      m = MASK_AL_MIN;
    end
    else if (a == OFS_AL_HOUR || a == OFS_AL_DATE)
    begin
      m = MASK_AL_HRDT;
    end
    else if (a == OFS_AL_WDAY)
    begin
      m = MASK_AL_WDAY;
    end
    else if (a <= OFS_LAST)
    begin
      m = 8'hFF;
    end
    return m;
  endfunction

  assign mif.we    = wr_stb && ptr_ok;
  assign mif.waddr = ptr_q[MEM_AW-1:0];
  assign mif.wdata = shift_q & wmask(ptr_q);
  // read next pointer early so data is ready at the byte start
  assign mif.raddr = ptr_q[MEM_AW-1:0] + ((state_q == ST_TXACK) ?
                     4'h1 : 4'h0);

  // ****************************************************
  // data line drive
  // ****************************************************
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sda_drv_q <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      sda_drv_q <= 1'b0;
    end
    // answer at the fall itself: one cycle later can reach the pin after
    // the clock rises again and read back as a start or stop
    else if (scl_fall && state_q == ST_RX && bit_cnt_q == BITS_BYTE)
    begin
      sda_drv_q <= first_q ? (shift_q[7:1] == SLAVE_ADDR) :
                   (!ptr_set_q || ptr_ok);
    end
    else if (scl_fall && state_q == ST_ACK)
    begin
      sda_drv_q <= first_q && rd_dir_q && !mif.rdata[7];
    end
    else if (scl_fall && state_q == ST_TX)
    begin
      sda_drv_q <= (bit_cnt_q != BITS_BYTE - 4'h1) && !shift_q[6];
    end
    else if (scl_fall && state_q == ST_TXACK)
    begin
      sda_drv_q <= mack_q && ptr_ok && !mif.rdata[7];
    end
    else
    begin
      case (state_q)
        // R15 ack low through ninth clock
        ST_ACK:   sda_drv_q <= ack_q;
        // R12 transmit bits change while clock low
        ST_TX:    sda_drv_q <= ~shift_q[7];
        // R9 R16 R17 released otherwise
        default:  sda_drv_q <= 1'b0;
      endcase
    end
  end

  assign SDA_OUT  = 1'b0;
  assign SDA_OE_N = ~sda_drv_q;

  // ****************************************************
  // alarm comparison
  // ****************************************************
  logic [7:0] al_min_q;
  logic [7:0] al_hour_q;
  logic [7:0] al_date_q;
  logic [7:0] al_wday_q;
  logic       aie_q;
  logic       af_q;
  logic       match_prev_q;
  logic       match;

  // shadow the alarm fields so comparison does not need the memory port
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      al_min_q  <= 8'h80;
      al_hour_q <= 8'h80;
      al_date_q <= 8'h80;
      al_wday_q <= 8'h80;
      aie_q     <= 1'b0;
    end
    else if (mif.we)
    begin
      if (ptr_q == OFS_AL_MIN)
      begin
        al_min_q <= mif.wdata;
      end
      else if (ptr_q == OFS_AL_HOUR)
      begin
        al_hour_q <= mif.wdata;
      end
      else if (ptr_q == OFS_AL_DATE)
      begin
        al_date_q <= mif.wdata;
      end
      else if (ptr_q == OFS_AL_WDAY)
      begin
        al_wday_q <= mif.wdata;
      end
      else if (ptr_q == OFS_CTRL2)
      begin
        aie_q <= mif.wdata[BIT_AIE];
      end
    end
  end

  // R1 R5 disabled fields always match
  assign match = (al_min_q[BIT_AE]  |
                  ((al_min_q & MASK_MIN) == (TIME_MIN & MASK_MIN))) &
                 (al_hour_q[BIT_AE] |
                  ((al_hour_q & MASK_HRDT) == (TIME_HOUR & MASK_HRDT))) &
                 (al_date_q[BIT_AE] |
                  ((al_date_q & MASK_HRDT) == (TIME_DATE & MASK_HRDT))) &
                 (al_wday_q[BIT_AE] |
                  ((al_wday_q & MASK_WDAY) == (TIME_WDAY & MASK_WDAY))) &
                 ~(al_min_q[BIT_AE] & al_hour_q[BIT_AE] &
                   al_date_q[BIT_AE] & al_wday_q[BIT_AE]);

  // R23 write zero clears the flag
  assign af_wr_clr = mif.we && ptr_q == OFS_CTRL2 && !mif.wdata[BIT_AF];

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      match_prev_q <= 1'b0;
      af_q         <= 1'b0;
    end
    else
    begin
      match_prev_q <= match;
      // R2 R3 R4 set on match entry, set beats clear
      if (match && !match_prev_q)
      begin
        af_q <= 1'b1;
      end
      else if (af_wr_clr)
      begin
        af_q <= 1'b0;
      end
    end
  end

  assign ALARM_FLAG = af_q;
  // R24 enable gates report
  assign ALARM_IRQ  = af_q & aie_q;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  af_set_a: assert property ((match && !match_prev_q) |=> af_q) // R2
    else $error("flag not set on match");
  af_hold_a: assert property ((af_q && !af_wr_clr) |=> af_q) // R3
    else $error("flag dropped without clear");
  af_reset_a: assert property ((!af_q && !(match && !match_prev_q))
    |=> !af_q) // R4
    else $error("flag set without new match");
  af_clr_a: assert property ((af_wr_clr && !(match && !match_prev_q))
    |=> !af_q) // R23
    else $error("flag not cleared by write zero");
  irq_gate_a: assert property (ALARM_IRQ == (af_q && aie_q)) // R24
    else $error("interrupt not gated");
  idle_rel_a: assert property ((state_q == ST_IDLE) |=> SDA_OE_N) // R9
    else $error("line driven while idle");
  start_rx_a: assert property (start_det |=> state_q == ST_RX) // R11
    else $error("start not taken");
  noack_a: assert property ((state_q == ST_WAITP) |=> SDA_OE_N) // R17
    else $error("line driven after nack");
  ack_low_a: assert property ((state_q == ST_ACK && ack_q && !start_det
    && !stop_det && !scl_fall) |=> !SDA_OE_N) // R15
    else $error("ack not driven");
  addr_a: assert property ((state_q == ST_ACK && first_q)
    |-> shift_q[7:1] == SLAVE_ADDR) // R18
    else $error("ack to foreign address");

  wr_cov: cover property (mif.we);
  rd_cov: cover property (state_q == ST_TX);
  alarm_cov: cover property (af_q && aie_q);
endmodule
`default_nettype wire

// file: rtcal_pkg.sv
// package: register map, field layout and link constants for the rtc alarm slave
package rtcal_pkg;
  localparam logic [7:0] OFS_CTRL2    = 8'h01;
  localparam logic [7:0] OFS_SECONDS  = 8'h02;
  localparam logic [7:0] OFS_MINUTES  = 8'h03;
  localparam logic [7:0] OFS_HOURS    = 8'h04;
  localparam logic [7:0] OFS_DATES    = 8'h05;
  localparam logic [7:0] OFS_WEEKDAY  = 8'h06;
  localparam logic [7:0] OFS_AL_MIN   = 8'h09;
  localparam logic [7:0] OFS_AL_HOUR  = 8'h0A;
  localparam logic [7:0] OFS_AL_DATE  = 8'h0B;
  localparam logic [7:0] OFS_AL_WDAY  = 8'h0C;
  localparam logic [7:0] OFS_LAST     = 8'h0F;
  localparam int         MEM_DEPTH    = 16;
  localparam int         MEM_AW       = 4;
  localparam int         BIT_AE       = 7;
  localparam int         BIT_AF       = 3;
  localparam int         BIT_AIE      = 1;
  localparam logic [7:0] MASK_MIN     = 8'h7F;
  localparam logic [7:0] MASK_HRDT    = 8'h3F;
  localparam logic [7:0] MASK_WDAY    = 8'h07;
  localparam logic [7:0] MASK_AL_MIN  = 8'hFF;
  localparam logic [7:0] MASK_AL_HRDT = 8'hBF;
  localparam logic [7:0] MASK_AL_WDAY = 8'h87;
  localparam logic [6:0] SLAVE_ADDR   = 7'h51;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAITP
  } rtcal_state_t;
endpackage

// file: rtcal_mem_if.sv
// interface: register memory port between the slave and its memory
`timescale 1ns/1ps
`default_nettype none
interface rtcal_mem_if;
  import rtcal_pkg::*;
  logic              we;
  logic [MEM_AW-1:0] waddr;
  logic [7:0]        wdata;
  logic [MEM_AW-1:0] raddr;
  logic [7:0]        rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface
`default_nettype wire

// file: rtcal_regmem.sv
// module: small register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rtcal_regmem
  import rtcal_pkg::*;
(
  // clock and reset
  input  wire logic  MCLK,
  input  wire logic  ARST_N,
  // memory port
  rtcal_mem_if.mem   port
);
  logic [7:0] mem_q [MEM_DEPTH];

  // no reset on storage; contents are software defined like the part's
  always_ff @(posedge MCLK)
  begin
    if (port.we)
    begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      port.rdata <= ZERO_BYTE;
    end
    else
    begin
      port.rdata <= mem_q[port.raddr];
    end
  end
endmodule
`default_nettype wire

// file: rtcal_master.sv
// partner model: two-wire bus master that frames and clocks every transfer
`timescale 1ns/1ps
`default_nettype none
module rtcal_master
(
  // bus lines, data already resolved with its pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // *******************
  // bus timing
  // *******************
  // quarter of a 320 ns bus period; the low phase takes three quarters so
  // the slave's answer, about five system clocks late, lands before rise
  localparam time QTR = 80ns;

  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic start();
    // odd offset keeps bus edges clear of system clock edges
    #7ns;
    #(3*QTR);
    sda_drv = 1'b1;
    #QTR;
    scl = 1'b1;
    #(2*QTR);
    sda_drv = 1'b0;
    #(2*QTR);
    scl = 1'b0;
  endtask

  task automatic stop();
    #QTR;
    sda_drv = 1'b0;
    #(2*QTR);
    scl = 1'b1;
    #(2*QTR);
    sda_drv = 1'b1;
    #(2*QTR);
  endtask

  task automatic xbit(input logic b, output logic r);
    #QTR;
    sda_drv = b;
    #(2*QTR);
    scl = 1'b1;
    // sample late in the high phase to give the slave the most time
    #(QTR - 10ns);
    r = sda;
    #10ns;
    scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, ack);
  endtask

  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, d[i]);
    xbit(nack, r);
    sda_drv = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// testbench: alarm match, register access and bus framing of the slave
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rtcal_pkg::*;
;
  typedef struct packed
  {
    logic [31:0] al;
    logic [31:0] tm;
    logic        flag;
  } rtcal_row_t;

  // alarm minute, hour, date, weekday; then time; then flag expected
  localparam rtcal_row_t rows [6] = '{
    '{32'h8080_8080, 32'h3023_3106, 1'b0},
    '{32'h3080_8080, 32'h3000_0000, 1'b1},
    '{32'h3080_8080, 32'h3100_0000, 1'b0},
    '{32'h8063_8080, 32'h0023_0000, 1'b1},
    '{32'h8080_3106, 32'h0000_3105, 1'b0},
    '{32'h80A3_317E, 32'h0023_3106, 1'b1}
  };
  localparam logic [31:0] al_mask =
    {MASK_AL_MIN, MASK_AL_HRDT, MASK_AL_HRDT, MASK_AL_WDAY};

  logic       mclk;
  logic       arst_n;
  logic [7:0] tm [4];
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe_n;
  logic       alarm_flag;
  logic       alarm_irq;
  logic       ack;
  logic [7:0] rd;
  int         fails;
  int         total_checks;
  int         cyc;
  // open drain: the pull-up wins unless some party pulls low
  wire        sda = sda_drv & (sda_oe_n | sda_out);

  rtcal_top i_rtcal_top
  (
    .MCLK       (mclk),
    .ARST_N     (arst_n),
    .SCL_IN     (scl),
    .SDA_IN     (sda),
    .SDA_OUT    (sda_out),
    .SDA_OE_N   (sda_oe_n),
    .TIME_MIN   (tm[0]),
    .TIME_HOUR  (tm[1]),
    .TIME_DATE  (tm[2]),
    .TIME_WDAY  (tm[3]),
    .ALARM_FLAG (alarm_flag),
    .ALARM_IRQ  (alarm_irq)
  );

  rtcal_master i_rtcal_master
  (
    .scl     (scl),
    .sda_drv (sda_drv),
    .sda     (sda)
  );

  initial
  begin
    mclk = 1'b0;
    forever
      #20 mclk = ~mclk;
  end

  // hang guard, about six times the expected run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails = fails + 1;
      close_out();
    end
  end

  // *******************
  // shared tasks
  // *******************
  task automatic close_out();
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask

  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {7'h00, e}, {7'h00, g});
  endtask

  task automatic send(input logic [7:0] d, input logic nack);
    i_rtcal_master.wbyte(d, ack);
    chkb("ack", nack, ack);
  endtask

  // mapped offsets only, the test-mode pair is never touched
  task automatic open_wr(input logic [7:0] p);
    i_rtcal_master.start();
    send(8'hA2, 1'b0);
    send(p, 1'b0);
  endtask

  task automatic wr1(input logic [7:0] p, input logic [7:0] d);
    open_wr(p);
    send(d, 1'b0);
    i_rtcal_master.stop();
  endtask

  task automatic wr4(input logic [7:0] p, input logic [31:0] d);
    open_wr(p);
    for (int k = 3; k >= 0; k--)
      send(d[8*k+:8], 1'b0);
    i_rtcal_master.stop();
  endtask

  task automatic rd4(input logic [7:0] p, input logic [31:0] e,
                     input logic simple);
    if (!simple)
      open_wr(p);
    i_rtcal_master.start();
    send(8'hA3, 1'b0);
    for (int k = 3; k >= 0; k--)
    begin
      i_rtcal_master.rbyte(rd, k == 0);
      chk("read", e[8*k+:8], rd);
    end
    repeat (8) @(posedge mclk);
    chkb("release", 1'b1, sda_oe_n);
    i_rtcal_master.stop();
  endtask

  task automatic set_time(input logic [31:0] t);
    @(posedge mclk);
    for (int k = 0; k < 4; k++)
      tm[k] <= t[8*(3-k)+:8];
    repeat (6) @(posedge mclk);
  endtask

  task automatic do_reset(input int n);
    arst_n <= 1'b0;
    repeat (n) @(posedge mclk);
    chkb("flag", 1'b0, alarm_flag);
    chkb("irq", 1'b0, alarm_irq);
    chkb("idle", 1'b1, sda_oe_n);
    chkb("sda_out", 1'b0, sda_out);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  // *******************
  // main sequence
  // *******************
  initial
  begin
    arst_n = 1'b0;
    foreach (tm[k])
      tm[k] = 8'h00;
    @(posedge mclk);
    do_reset(12);
    foreach (rows[i])
    begin
      set_time(32'h7F3F_3F07);
      wr4(8'h09, rows[i].al);
      wr1(8'h01, 8'h00);
      chkb("flag", 1'b0, alarm_flag);
      set_time(rows[i].tm);
      chkb("flag", rows[i].flag, alarm_flag);
      rd4(8'h09, rows[i].al & al_mask, 1'b0);
    end
    // flag stays up, write-one keeps, new entry needed after a clear
    set_time(32'h0023_3005);
    chkb("flag", 1'b1, alarm_flag);
    wr1(8'h01, 8'h08);
    chkb("flag", 1'b1, alarm_flag);
    chkb("irq", 1'b0, alarm_irq);
    set_time(32'h0023_3106);
    wr1(8'h01, 8'h02);
    repeat (50) @(posedge mclk);
    chkb("flag", 1'b0, alarm_flag);
    set_time(32'h0023_3005);
    set_time(32'h0023_3106);
    chkb("flag", 1'b1, alarm_flag);
    chkb("irq", 1'b1, alarm_irq);
    // last register accepted, one past it refused
    open_wr(8'h0F);
    send(8'h00, 1'b0);
    send(8'h00, 1'b1);
    i_rtcal_master.stop();
    i_rtcal_master.start();
    send(8'hA4, 1'b1);
    i_rtcal_master.stop();
    wr4(8'h03, 32'h4217_0305);
    open_wr(8'h03);
    i_rtcal_master.stop();
    rd4(8'h00, 32'h4217_0305, 1'b1);
    // second reset in mid-run returns alarms to disabled
    do_reset(3);
    set_time(32'h0023_3005);
    set_time(32'h0023_3106);
    chkb("flag", 1'b0, alarm_flag);
    // storage keeps its contents through reset, only the shadows clear
    rd4(8'h09, 32'h80A3_3106, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
